// [hw/remap_top.sv]
// Remote target address remap: two six-entry alias tables, AXI4-Lite registers, address rewrite.
// Assumes the I2C front end presents each address byte after a start as a one-cycle strobe,
// and that the control channel takes a forwarded address on the cycle it is offered.
//
// Function
// RULE1: Each remote entry holds a 7-bit target address in bits 7:1; bit 0 reserved.
// RULE2: A transaction to alias N is rewritten to remote entry N before forwarding.
// RULE3: A remote entry of zero blocks forwarding for that target.
// RULE4: With second port select set, entry accesses use the second link's table.
// RULE5: Each target has a 7-bit alias in bits 7:1; zero alias disables it.
// RULE6: Received address is compared with enabled aliases; no match means no forwarding.
`include "remap_params.svh"

module remap_top
  import remap_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic [`RT_AXI_AW-1:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [`RT_AXI_AW-1:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic i2c_addr_valid,
  input addr7_t i2c_addr,
  input logic i2c_rw,
  input logic i2c_link,
  output logic bcc_fwd_valid,
  output addr7_t bcc_fwd_addr,
  output logic bcc_fwd_rw,
  output logic bcc_fwd_link,
  output logic i2c_addr_ignored
);

  remap_state_t s_q;
  remap_state_t s_d;

  reg_kind_t wr_kind;
  logic [2:0] wr_entry;
  reg_kind_t rd_kind;
  logic [2:0] rd_entry;
  logic lk_match;
  logic lk_blocked;
  logic [2:0] lk_entry;
  addr7_t lk_remote;
  logic aw_take;
  logic w_take;
  logic ar_take;

  // Protection bits carry no meaning for this block.
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1], s_axi_wdata[31:8]};

  // Write decode works on the latched index so the address may arrive before or after data.
  remap_decode u_wr_decode (
    .idx(s_q.aw_idx),
    .kind(wr_kind),
    .entry(wr_entry)
  );

  remap_decode u_rd_decode (
    .idx(s_axi_araddr[`RT_AXI_AW-1:2]),
    .kind(rd_kind),
    .entry(rd_entry)
  );

  // The link's own table is used, independent of the register port select.
  remap_lookup u_lookup (
    .alias_tbl(s_q.alias_tbl[i2c_link]),
    .remote_tbl(s_q.remote[i2c_link]),
    .addr_in(i2c_addr),
    .match(lk_match),
    .blocked(lk_blocked),
    .entry(lk_entry),
    .remote_addr(lk_remote)
  );

  // Handshake outputs are combinational from the registered state.
  assign s_axi_awready = (s_q.wst == W_IDLE) && !s_q.aw_have;
  assign s_axi_wready = (s_q.wst == W_IDLE) && !s_q.w_have;
  assign s_axi_bvalid = (s_q.wst == W_RESP);
  assign s_axi_arready = (s_q.rst == R_IDLE);
  assign s_axi_rvalid = (s_q.rst == R_DATA);
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // Data outputs come straight from flip-flops.
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign bcc_fwd_valid = s_q.fwd_valid;
  assign bcc_fwd_addr = s_q.fwd_addr;
  assign bcc_fwd_rw = s_q.fwd_rw;
  assign bcc_fwd_link = s_q.fwd_link;
  assign i2c_addr_ignored = s_q.drop;

  // Next state: bus slave, table writes, read mux and the address rewrite.
  always_comb begin
    s_d = s_q;
    s_d.fwd_valid = 1'b0;
    s_d.drop = 1'b0;

    // Write address and data are caught independently, in either order.
    unique case (s_q.wst)
      W_IDLE: begin
        if (aw_take) begin
          s_d.aw_have = 1'b1;
          s_d.aw_idx = s_axi_awaddr[`RT_AXI_AW-1:2];
        end
        if (w_take) begin
          s_d.w_have = 1'b1;
          s_d.w_data = s_axi_wdata[7:0];
          s_d.w_strb0 = s_axi_wstrb[0];
        end
        if (s_q.aw_have && s_q.w_have) begin
          s_d.aw_have = 1'b0;
          s_d.w_have = 1'b0;
          s_d.wst = W_RESP;
          s_d.bresp = `RT_RESP_OKAY;
          // Only the low byte lane holds data; a write without it changes nothing.
          unique case (wr_kind)
            K_REMOTE: begin
              if (s_q.w_strb0) begin
                // Bit 0 is reserved and not stored.
                s_d.remote[s_q.port_sel][wr_entry] =
                  s_q.w_data[`RT_ADDR_MSB:`RT_ADDR_LSB]; // [RULE1] [RULE4]
              end
            end
            K_ALIAS: begin
              if (s_q.w_strb0) begin
                s_d.alias_tbl[s_q.port_sel][wr_entry] =
                  s_q.w_data[`RT_ADDR_MSB:`RT_ADDR_LSB]; // [RULE5] [RULE4]
              end
            end
            K_CTRL: begin
              if (s_q.w_strb0) begin
                s_d.port_sel = s_q.w_data[`RT_CTRL_PORT_SEL_BIT];
              end
            end
            K_STATUS: begin
              // Status is read-only; the write is accepted and has no effect.
            end
            K_NONE: begin
              s_d.bresp = `RT_RESP_SLVERR;
            end
            default: begin
              s_d.bresp = `RT_RESP_SLVERR;
            end
          endcase
        end
      end
      W_RESP: begin
        if (s_axi_bready) begin
          s_d.wst = W_IDLE;
        end
      end
      default: begin
        s_d.wst = W_IDLE;
      end
    endcase

    // A read is decoded in the cycle its address is taken and answered on the next.
    unique case (s_q.rst)
      R_IDLE: begin
        if (ar_take) begin
          s_d.rst = R_DATA;
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `RT_RESP_OKAY;
          unique case (rd_kind)
            K_REMOTE: begin
              s_d.rdata[`RT_ADDR_MSB:`RT_ADDR_LSB] = s_q.remote[s_q.port_sel][rd_entry]; // [RULE4]
            end
            K_ALIAS: begin
              s_d.rdata[`RT_ADDR_MSB:`RT_ADDR_LSB] =
                s_q.alias_tbl[s_q.port_sel][rd_entry]; // [RULE4]
            end
            K_CTRL: begin
              s_d.rdata[`RT_CTRL_PORT_SEL_BIT] = s_q.port_sel;
            end
            K_STATUS: begin
              s_d.rdata[`RT_ST_LAST_HIT_BIT] = s_q.last_hit;
              s_d.rdata[`RT_ST_LAST_BLOCK_BIT] = s_q.last_blocked;
              s_d.rdata[`RT_ST_ENTRY_LSB +: 3] = s_q.last_entry;
              s_d.rdata[`RT_ST_LINK_BIT] = s_q.last_link;
              s_d.rdata[`RT_ST_PORT_SEL_BIT] = s_q.port_sel;
              s_d.rdata[`RT_ST_COUNT_LSB +: 8] = s_q.fwd_count;
            end
            K_NONE: begin
              s_d.rresp = `RT_RESP_SLVERR;
            end
            default: begin
              s_d.rresp = `RT_RESP_SLVERR;
            end
          endcase
        end
      end
      R_DATA: begin
        if (s_axi_rready) begin
          s_d.rst = R_IDLE;
        end
      end
      default: begin
        s_d.rst = R_IDLE;
      end
    endcase

    // Address rewrite: one cycle after the strobe, either a forward or an ignore pulse.
    // A table write in the same cycle takes effect only for the next address.
    if (i2c_addr_valid) begin
      s_d.last_hit = lk_match;
      s_d.last_blocked = lk_blocked;
      s_d.last_entry = lk_match ? 3'(lk_entry + 3'h1) : 3'h0;
      s_d.last_link = i2c_link;
      if (lk_match && !lk_blocked) begin
        s_d.fwd_valid = 1'b1; // [RULE2] [RULE6]
        s_d.fwd_addr = lk_remote; // [RULE2]
        s_d.fwd_rw = i2c_rw;
        s_d.fwd_link = i2c_link;
        s_d.fwd_count = 8'(s_q.fwd_count + 8'h01);
      end else begin
        s_d.drop = 1'b1; // [RULE3] [RULE6]
      end
    end

    // Synchronous reset puts every field at its documented or neutral value.
    if (!aresetn) begin
      s_d = '0;
      s_d.wst = W_IDLE;
      s_d.rst = R_IDLE;
      s_d.bresp = `RT_RESP_OKAY;
      s_d.rresp = `RT_RESP_OKAY;
      for (int p = 0; p < 2; p++) begin
        for (int e = 0; e < `RT_ENTRIES; e++) begin
          s_d.remote[p][e] = `RT_TARGET_RESET;
          s_d.alias_tbl[p][e] = `RT_TARGET_RESET;
        end
      end
    end
  end

  // Single state register.
  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

endmodule

// [hw/remap_params.svh]
// Constants of the remote target address remap block: register indices, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus where the byte address is four times the index.
`ifndef REMAP_PARAMS_SVH
`define REMAP_PARAMS_SVH

// Register indices; the byte address is the index times four.
`define RT_IDX_REMOTE_1 8'h70
`define RT_IDX_REMOTE_2 8'h71
`define RT_IDX_REMOTE_3 8'h72
`define RT_IDX_REMOTE_4 8'h73
`define RT_IDX_REMOTE_5 8'h74
`define RT_IDX_REMOTE_6 8'h75
`define RT_IDX_ALIAS_1 8'h77
`define RT_IDX_ALIAS_2 8'h78
`define RT_IDX_ALIAS_3 8'h79
`define RT_IDX_ALIAS_4 8'h7a
`define RT_IDX_ALIAS_5 8'h7b
`define RT_IDX_ALIAS_6 8'h7c
`define RT_IDX_CTRL 8'h7d
`define RT_IDX_STATUS 8'h7e

// Table geometry and field positions.
`define RT_ENTRIES 6
`define RT_ADDR_MSB 7
`define RT_ADDR_LSB 1
`define RT_CTRL_PORT_SEL_BIT 0
`define RT_AXI_AW 10

// Reset values.
`define RT_REG_RESET 8'h00
`define RT_TARGET_RESET 7'h00

// Status register field positions.
`define RT_ST_LAST_HIT_BIT 0
`define RT_ST_LAST_BLOCK_BIT 1
`define RT_ST_ENTRY_LSB 2
`define RT_ST_LINK_BIT 5
`define RT_ST_PORT_SEL_BIT 6
`define RT_ST_COUNT_LSB 8

// AXI response codes.
`define RT_RESP_OKAY 2'h0
`define RT_RESP_SLVERR 2'h2

`endif

// [hw/remap_pkg.sv]
// Types shared by the remote target address remap block.
// Assumes remap_params.svh is on the include path.
`include "remap_params.svh"

package remap_pkg;

  typedef logic [6:0] addr7_t;
  typedef addr7_t [`RT_ENTRIES-1:0] table_t;

  // Kind of register a word index selects.
  typedef enum logic [4:0] {
    K_NONE = 5'b00001,
    K_REMOTE = 5'b00010,
    K_ALIAS = 5'b00100,
    K_CTRL = 5'b01000,
    K_STATUS = 5'b10000
  } reg_kind_t;

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_DATA = 2'b10
  } rd_state_t;

  // Whole state of the top module.
  typedef struct packed {
    wr_state_t wst;
    logic aw_have;
    logic [7:0] aw_idx;
    logic w_have;
    logic [7:0] w_data;
    logic w_strb0;
    logic [1:0] bresp;
    rd_state_t rst;
    logic [31:0] rdata;
    logic [1:0] rresp;
    table_t [1:0] remote;
    table_t [1:0] alias_tbl;
    logic port_sel;
    logic fwd_valid;
    addr7_t fwd_addr;
    logic fwd_rw;
    logic fwd_link;
    logic drop;
    logic last_hit;
    logic last_blocked;
    logic [2:0] last_entry;
    logic last_link;
    logic [7:0] fwd_count;
  } remap_state_t;

endpackage

// [hw/remap_decode.sv]
// Word index decoder for the remap register map.
// Assumes the index is the AXI byte address divided by four.
`include "remap_params.svh"

module remap_decode
  import remap_pkg::*;
(
  input logic [7:0] idx,
  output reg_kind_t kind,
  output logic [2:0] entry
);

  // Ranges are contiguous, so one compare pair per table replaces six equalities.
  always_comb begin
    kind = K_NONE;
    entry = 3'h0;
    if (idx >= `RT_IDX_REMOTE_1 && idx <= `RT_IDX_REMOTE_6) begin
      kind = K_REMOTE;
      entry = 3'(idx - `RT_IDX_REMOTE_1);
    end else if (idx >= `RT_IDX_ALIAS_1 && idx <= `RT_IDX_ALIAS_6) begin
      kind = K_ALIAS;
      entry = 3'(idx - `RT_IDX_ALIAS_1);
    end else if (idx == `RT_IDX_CTRL) begin
      kind = K_CTRL;
    end else if (idx == `RT_IDX_STATUS) begin
      kind = K_STATUS;
    end
  end

endmodule

// [hw/remap_lookup.sv]
// Alias match for one link's table: finds the entry whose alias equals the received address.
// Assumes both tables are stable for the cycle in which the address is presented.
`include "remap_params.svh"

module remap_lookup
  import remap_pkg::*;
(
  input table_t alias_tbl,
  input table_t remote_tbl,
  input addr7_t addr_in,
  output logic match,
  output logic blocked,
  output logic [2:0] entry,
  output addr7_t remote_addr
);

  logic [`RT_ENTRIES-1:0] hit_vec;

  // A zero alias never matches, so a cleared entry is out of the table.
  for (genvar gi = 0; gi < `RT_ENTRIES; gi++) begin : g_cmp
    assign hit_vec[gi] = (alias_tbl[gi] != `RT_TARGET_RESET) && (alias_tbl[gi] == addr_in); // [RULE5] [RULE6]
  end

  // Lowest entry wins when software has programmed the same alias twice.
  always_comb begin
    entry = 3'h0;
    remote_addr = `RT_TARGET_RESET;
    for (int i = `RT_ENTRIES - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        entry = 3'(i);
        remote_addr = remote_tbl[i]; // [RULE2]
      end
    end
  end

  assign match = |hit_vec;
  assign blocked = match && (remote_addr == `RT_TARGET_RESET); // [RULE3]

endmodule

// [verif/remap_checker.sv]
// Assertions on the remap block's strobe, forward and read channel ports.
// Assumes one clock domain, aclk, with a synchronous active-low reset.
module remap_checker
  import remap_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic i2c_addr_valid,
  input addr7_t i2c_addr,
  input logic i2c_rw,
  input logic i2c_link,
  input logic bcc_fwd_valid,
  input addr7_t bcc_fwd_addr,
  input logic bcc_fwd_rw,
  input logic bcc_fwd_link,
  input logic i2c_addr_ignored
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A forward must carry the strobe's direction and link from the cycle before.
  sequence strobe_s;
    i2c_addr_valid;
  endsequence
  sequence fwd_s;
    bcc_fwd_valid && bcc_fwd_rw == $past(i2c_rw) && bcc_fwd_link == $past(i2c_link);
  endsequence
  one_answer_a: assert property (strobe_s |=> bcc_fwd_valid != i2c_addr_ignored)
    else $error("strobe gave no single answer");
  quiet_a: assert property (!i2c_addr_valid |=> !bcc_fwd_valid && !i2c_addr_ignored)
    else $error("answer without strobe");
  zero_alias_a: assert property (strobe_s and i2c_addr == 7'h00 |=> i2c_addr_ignored)
    else $error("zero address forwarded");
  fwd_copy_a: assert property (strobe_s ##1 bcc_fwd_valid |-> fwd_s)
    else $error("forward fields wrong");
  fwd_nonzero_a: assert property (bcc_fwd_valid |-> bcc_fwd_addr != 7'h00)
    else $error("zero remote forwarded");
  // The first edge after reset is skipped, since the reset edge itself cleared the address.
  fwd_hold_a: assert property ($past(aresetn) && !bcc_fwd_valid |-> $stable(bcc_fwd_addr))
    else $error("forward address moved");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind remap_top remap_checker chk (.*);

// [verif/remap_partner.sv]
// Far side model: the local controller front end presenting received addresses.
// Assumes the remap block samples each strobe at a rising edge of aclk.
module remap_partner
  import remap_pkg::*;
(
  input logic aclk,
  output logic i2c_addr_valid,
  output addr7_t i2c_addr,
  output logic i2c_rw,
  output logic i2c_link
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle state at time zero.
  initial begin
    i2c_addr_valid = 1'b0;
    i2c_addr = 7'h00;
    i2c_rw = 1'b0;
    i2c_link = 1'b0;
  end
  // One-cycle strobe; the address and direction lines then show the inverse so a stale address never passes.
  task automatic send(input addr7_t a, input logic l);
    @(posedge aclk);
    i2c_addr_valid <= 1'b1;
    i2c_addr <= a;
    i2c_rw <= a[0];
    i2c_link <= l;
    @(posedge aclk);
    i2c_addr_valid <= 1'b0;
    i2c_addr <= ~a;
    i2c_rw <= ~a[0];
  endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the remap block: AXI4-Lite register tasks and strobe tests.
// Assumes remap_params.svh is on the include path.
`include "remap_params.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module tb_top
  import remap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = '0;
  logic wvalid = 1'b0;
  logic [1:0] bresp, rresp;
  logic bready = 1'b0;
  logic [9:0] araddr = '0;
  logic arvalid = 1'b0;
  logic [31:0] rdata;
  logic rready = 1'b0;
  logic i2c_addr_valid, i2c_rw, i2c_link, bcc_fwd_valid, bcc_fwd_rw, bcc_fwd_link, ign;
  addr7_t i2c_addr, bcc_fwd_addr;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  remap_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .i2c_addr_valid(i2c_addr_valid), .i2c_addr(i2c_addr), .i2c_rw(i2c_rw),
    .i2c_link(i2c_link), .bcc_fwd_valid(bcc_fwd_valid), .bcc_fwd_addr(bcc_fwd_addr),
    .bcc_fwd_rw(bcc_fwd_rw), .bcc_fwd_link(bcc_fwd_link), .i2c_addr_ignored(ign));
  remap_partner p (.aclk(aclk), .i2c_addr_valid(i2c_addr_valid), .i2c_addr(i2c_addr),
    .i2c_rw(i2c_rw), .i2c_link(i2c_link));
  // Clock at 50 MHz.
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well beyond the fewer than two hundred cycles the tests need.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      conclude;
    end
  end
  // Write one word; readies are looked at on the falling edge to stay clear of races.
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge aclk); while (!(awready && wready));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(negedge aclk); while (!bvalid);
    `CHK(bresp, er)
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  // Read one word; rready comes a cycle late so the answer must stand.
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(negedge aclk); while (!rvalid);
    `CHK(rdata, e)
    `CHK(rresp, er)
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Present one address and check the single answer a cycle later.
  task automatic st(input addr7_t a, input logic l, input logic ev, input addr7_t ea);
    p.send(a, l);
    #1;
    `CHK(bcc_fwd_valid, ev)
    `CHK(ign, !ev)
    if (ev) `CHK(bcc_fwd_addr, ea)
    if (ev) `CHK(bcc_fwd_link, l)
    if (ev) `CHK(bcc_fwd_rw, a[0])
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (logic [6:0] n = 1; n < 7; n++) rd(8'h6f + {1'b0, n}, '0, 2'h0);
    rd(8'h76, '0, 2'h2);
    $display("reset test done");
    for (logic [6:0] n = 1; n < 7; n++) begin
      wr(8'h6f + {1'b0, n}, {7'h10 + n, 1'b1}, 2'h0);
      wr(8'h76 + {1'b0, n}, {7'h20 + n, 1'b0}, 2'h0);
      rd(8'h6f + {1'b0, n}, {24'h0, 7'h10 + n, 1'b0}, 2'h0);
      st(7'h20 + n, 1'b0, 1'b1, 7'h10 + n);
    end
    st(7'h55, 1'b0, 1'b0, 7'h00);
    st(7'h00, 1'b0, 1'b0, 7'h00);
    wr(`RT_IDX_REMOTE_3, 8'h00, 2'h0);
    st(7'h23, 1'b0, 1'b0, 7'h00);
    $display("remap test done");
    wr(`RT_IDX_CTRL, 8'h01, 2'h0);
    wr(`RT_IDX_REMOTE_1, 8'h80, 2'h0);
    wr(`RT_IDX_ALIAS_1, 8'h83, 2'h0);
    rd(`RT_IDX_REMOTE_1, 32'h80, 2'h0);
    wr(`RT_IDX_CTRL, 8'h00, 2'h0);
    rd(`RT_IDX_REMOTE_1, 32'h22, 2'h0);
    st(7'h41, 1'b1, 1'b1, 7'h40);
    st(7'h41, 1'b0, 1'b0, 7'h00);
    st(7'h21, 1'b1, 1'b0, 7'h00);
    rd(`RT_IDX_CTRL, 32'h0, 2'h0);
    // Seven forwards so far; the last strobe came in on link 1 and matched nothing.
    rd(`RT_IDX_STATUS, 32'h720, 2'h0);
    $display("port test done");
    conclude;
  end
endmodule
